// file: lcd_segment_driver.sv
// Overview of operation
// - Low clock bases: 2^9, 2^8; duty-scaled frames
// - Reset opens the panel power switch
// - Switch open: all pins at top supply
// - Display enable closes the power switch
// - Switch stays closed through blanking
// - Hold opens switch, display off
// - Hold release restores prior switch state
// - Display data from words 20h to 33h
// - Hardware fetches display data autonomously
// - Data one lights, zero leaves dark
// - Lit only at full panel voltage
// - Blanking drives non-lighting common level
// - Segments follow data while blanked
// - Static unlit segment: zero voltage
// - Static blanking: common at half level
// - Outputs defined from reset onward
// - Duty select picks one of four methods
// - High clock bases 2^16,2^15,2^13,2^12
`timescale 1ns/1ps
module lcd_segment_driver import lcd_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_hold,
	input wire logic i_display_enable_bit,
	input wire logic [1:0] i_duty_select,
	input wire logic [1:0] i_base_freq_select,
	input wire logic i_dual_clock_mode,
	input wire logic i_low_clk,
	input wire logic [3:0] i_mem_data,
	output logic [6:0] o_mem_addr,
	output logic o_power_switch,
	output logic [SEGS*LVL_W-1:0] o_segment_output,
	output logic [COMS*LVL_W-1:0] o_common_output
);
	typedef struct packed {
		switch_type sw;
		logic pwr;
		logic [1:0] slot;
		logic pol;
		logic [SEGS*LVL_W-1:0] segment_output;
		logic [COMS*LVL_W-1:0] common_output;
	} drv_type;

	drv_type st;
	drv_type next_st;
	logic tick;
	logic [SEGS*COMS-1:0] cache;
	logic [1:0] last_slot;
	logic [SEGS*LVL_W-1:0] seg_lvls;
	logic [COMS*LVL_W-1:0] com_lvls;

	lcd_prescaler u_prescaler (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_dual_clock_mode(i_dual_clock_mode),
		.i_base_freq_select(i_base_freq_select),
		.i_low_clk(i_low_clk),
		.o_tick(tick)
	);

	lcd_fetch u_fetch (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_mem_data(i_mem_data),
		.o_mem_addr(o_mem_addr),
		.o_cache(cache)
	);

	// Final slot of a frame; static runs four ticks to keep frame = base
	function automatic logic [1:0] frame_last(input logic [1:0] duty);
		logic [1:0] r;
		case (duty)
			DUTY_HALF: r = 2'h1;
			DUTY_THIRD: r = 2'h2;
			default: r = 2'h3;
		endcase
		return r;
	endfunction : frame_last

	// Level of a common not selected in this slot
	function automatic logic [2:0] com_idle(input logic [1:0] duty,
		input logic pol);
		logic [2:0] r;
		case (duty)
			DUTY_STATIC: r = LV_HALF;
			DUTY_HALF: r = LV_HALF;
			default: r = pol ? LV_TWO_THIRD : LV_THIRD;
		endcase
		return r;
	endfunction : com_idle

	// Level of a common in its own slot
	function automatic logic [2:0] com_active(input logic pol);
		return pol ? LV_TOP : LV_BOTTOM;
	endfunction : com_active

	// Segment level for a given data bit
	function automatic logic [2:0] seg_level(input logic [1:0] duty,
		input logic lit, input logic pol);
		logic [2:0] r;
		if (lit) begin
			r = pol ? LV_BOTTOM : LV_TOP;
		end else if (duty == DUTY_THIRD || duty == DUTY_QUARTER) begin
			r = pol ? LV_THIRD : LV_TWO_THIRD;
		end else begin
			r = com_active(pol);
		end
		return r;
	endfunction : seg_level

	assign last_slot = frame_last(i_duty_select);

	generate
		for (genvar c = 0; c < COMS; c++) begin : g_com
			logic [1:0] cidx;
			logic in_use;
			logic chosen;
			assign cidx = 2'(c);
			assign in_use = (i_duty_select == DUTY_STATIC) ? (c == 0)
				: (cidx <= last_slot);
			assign chosen = (i_duty_select == DUTY_STATIC) || (st.slot == cidx);
			assign com_lvls[c*LVL_W +: LVL_W] =
				!i_display_enable_bit ? com_idle(i_duty_select, st.pol)
				: ((in_use && chosen) || i_duty_select == DUTY_STATIC)
				? com_active(st.pol)
				: com_idle(i_duty_select, st.pol);
		end
		for (genvar s = 0; s < SEGS; s++) begin : g_seg
			logic lit;
			// Static uses bit 0 only
			assign lit = (i_duty_select == DUTY_STATIC) ? cache[s*COMS]
				: cache[s*COMS + int'(st.slot)];
			// Segments keep following the data while blanked
			assign seg_lvls[s*LVL_W +: LVL_W] =
				seg_level(i_duty_select, lit, st.pol);
		end
	endgenerate

	always_comb begin
		next_st = st;
		// Switch state survives hold so release restores it
		case (st.sw)
			SW_OPEN: begin
				if (i_display_enable_bit && !i_hold) begin
					next_st.sw = SW_CLOSED;
				end
			end
			SW_CLOSED: begin
				next_st.sw = SW_CLOSED;
			end
			default: begin
				next_st.sw = SW_OPEN;
			end
		endcase
		next_st.pwr = (next_st.sw == SW_CLOSED) && !i_hold;
		if (tick) begin
			if (st.slot >= last_slot) begin
				next_st.slot = SLOT_RESET;
				next_st.pol = ~st.pol;
			end else begin
				next_st.slot = st.slot + 2'h1;
			end
		end
		if (next_st.pwr) begin
			next_st.segment_output = seg_lvls;
			next_st.common_output = com_lvls;
		end else begin
			next_st.segment_output = SEG_RESET;
			next_st.common_output = COM_RESET;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st.sw <= SW_OPEN;
			st.pwr <= 1'b0;
			st.slot <= SLOT_RESET;
			st.pol <= 1'b0;
			st.segment_output <= SEG_RESET;
			st.common_output <= COM_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign o_power_switch = st.pwr;
	assign o_segment_output = st.segment_output;
	assign o_common_output = st.common_output;

	hold_opens_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_hold |=> !o_power_switch)
		else $error("Power switch closed during hold");

	enable_closes_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_display_enable_bit && !i_hold) |=> o_power_switch)
		else $error("Display enable did not close the switch");

	stays_closed_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_power_switch && !i_hold) |=> o_power_switch)
		else $error("Switch opened without reset or hold");

	dark_when_open_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!o_power_switch |-> (o_segment_output == SEG_RESET
			&& o_common_output == COM_RESET))
		else $error("Pins not at top supply with switch open");

	hold_restore_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st.sw == SW_CLOSED && $fell(i_hold)) |=> o_power_switch)
		else $error("Hold release did not restore the switch");

	static_blank_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st.sw == SW_CLOSED && !i_hold && !i_display_enable_bit
			&& i_duty_select == DUTY_STATIC)
		|=> o_common_output[2:0] == LV_HALF)
		else $error("Static blanking common not at half level");

	blank_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st.sw == SW_CLOSED && !i_hold && !i_display_enable_bit
			&& i_duty_select == DUTY_QUARTER)
		|=> (o_common_output[2:0] == LV_THIRD
			|| o_common_output[2:0] == LV_TWO_THIRD))
		else $error("Blanked common at a lighting level");

	static_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st.sw == SW_CLOSED && !i_hold && i_display_enable_bit
			&& i_duty_select == DUTY_STATIC && !cache[0])
		|=> o_segment_output[2:0] == o_common_output[2:0])
		else $error("Static unlit segment has voltage across it");

	lit_full_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(st.sw == SW_CLOSED && !i_hold && i_display_enable_bit
			&& i_duty_select == DUTY_STATIC && cache[0])
		|=> (o_segment_output[2:0] ^ o_common_output[2:0]) == 3'h6)
		else $error("Lit static segment not at full voltage");

	addr_range_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_mem_addr != 7'h0 |-> (o_mem_addr >= DISP_FIRST
			&& o_mem_addr <= DISP_LAST))
		else $error("Fetch address outside display area");

	slot_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(tick && st.slot < last_slot && $stable(i_duty_select))
		|=> st.slot == $past(st.slot) + 2'h1)
		else $error("Slot did not advance on tick");

	frame_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(tick && st.slot == last_slot) |=> (st.slot == SLOT_RESET
			&& st.pol != $past(st.pol)))
		else $error("Frame did not wrap after last slot");

	fetch_walk_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_mem_addr == DISP_LAST |=> o_mem_addr == DISP_FIRST)
		else $error("Fetch did not wrap to start of area");

	no_tick_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!tick |=> st.slot == $past(st.slot))
		else $error("Slot moved without a tick");
endmodule : lcd_segment_driver

// file: lcd_pkg.sv
package lcd_pkg;
	localparam int SEGS = 20;
	localparam int COMS = 4;
	localparam int LVL_W = 3;
	localparam logic [6:0] DISP_FIRST = 7'h20;
	localparam logic [6:0] DISP_LAST = 7'h33;
	localparam logic [4:0] LAST_IDX = 5'h13;
	// Drive methods
	localparam logic [1:0] DUTY_STATIC = 2'h0;
	localparam logic [1:0] DUTY_HALF = 2'h1;
	localparam logic [1:0] DUTY_THIRD = 2'h2;
	localparam logic [1:0] DUTY_QUARTER = 2'h3;
	// Base frequency codes
	localparam logic [1:0] BASE_SEL_0 = 2'h0;
	localparam logic [1:0] BASE_SEL_1 = 2'h1;
	localparam logic [1:0] BASE_SEL_2 = 2'h2;
	localparam logic [1:0] BASE_SEL_3 = 2'h3;
	// Base divider exponents, high clock
	localparam logic [4:0] HI_EXP_3 = 5'h10;
	localparam logic [4:0] HI_EXP_2 = 5'h0f;
	localparam logic [4:0] HI_EXP_1 = 5'h0d;
	localparam logic [4:0] HI_EXP_0 = 5'h0c;
	// Base divider exponents, low clock
	localparam logic [4:0] LO_EXP_2 = 5'h09;
	localparam logic [4:0] LO_EXP_1 = 5'h08;
	// Four slot ticks per base period
	localparam logic [4:0] SLOT_EXP = 5'h02;
	// Pin levels in sixths of the panel voltage below the top supply
	localparam logic [2:0] LV_TOP = 3'h0;
	localparam logic [2:0] LV_THIRD = 3'h2;
	localparam logic [2:0] LV_HALF = 3'h3;
	localparam logic [2:0] LV_TWO_THIRD = 3'h4;
	localparam logic [2:0] LV_BOTTOM = 3'h6;
	localparam logic [SEGS*LVL_W-1:0] SEG_RESET = '0;
	localparam logic [COMS*LVL_W-1:0] COM_RESET = '0;
	localparam logic [1:0] SLOT_RESET = 2'h0;
	typedef enum logic [1:0] {
		SW_OPEN = 2'b01,
		SW_CLOSED = 2'b10
	} switch_type;
endpackage : lcd_pkg

// file: lcd_prescaler.sv
`timescale 1ns/1ps
module lcd_prescaler import lcd_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_dual_clock_mode,
	input wire logic [1:0] i_base_freq_select,
	input wire logic i_low_clk,
	output logic o_tick
);
	typedef struct packed {
		logic [15:0] hi_cnt;
		logic [7:0] lo_cnt;
		logic lo_prev;
		logic tick;
	} pre_type;

	pre_type st;
	pre_type next_st;
	logic [4:0] shift;
	logic [15:0] mask;
	logic lo_edge;

	function automatic logic [4:0] base_exp(input logic dual,
		input logic [1:0] sel);
		logic [4:0] e;
		e = HI_EXP_0;
		if (dual) begin
			e = sel[1] ? LO_EXP_2 : LO_EXP_1;
		end else begin
			case (sel)
				BASE_SEL_3: e = HI_EXP_3;
				BASE_SEL_2: e = HI_EXP_2;
				BASE_SEL_1: e = HI_EXP_1;
				default: e = HI_EXP_0;
			endcase
		end
		return e;
	endfunction : base_exp

	always_comb begin
		next_st = st;
		shift = base_exp(i_dual_clock_mode, i_base_freq_select) - SLOT_EXP;
		mask = (16'h1 << shift) - 16'h1;
		lo_edge = i_low_clk & ~st.lo_prev;
		next_st.lo_prev = i_low_clk;
		next_st.hi_cnt = st.hi_cnt + 16'h1;
		next_st.tick = 1'b0;
		if (i_dual_clock_mode) begin
			if (lo_edge) begin
				next_st.lo_cnt = st.lo_cnt + 8'h1;
				next_st.tick = (st.lo_cnt & mask[7:0]) == mask[7:0];
			end
		end else begin
			next_st.tick = (st.hi_cnt & mask) == mask;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_tick = st.tick;
endmodule : lcd_prescaler

// file: lcd_fetch.sv
`timescale 1ns/1ps
module lcd_fetch import lcd_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_mem_data,
	output logic [6:0] o_mem_addr,
	output logic [SEGS*COMS-1:0] o_cache
);
	typedef struct packed {
		logic [4:0] idx;
		logic [4:0] idx_d;
		logic primed;
		logic [6:0] addr;
		logic [SEGS-1:0][COMS-1:0] cache;
	} fetch_type;

	fetch_type st;
	fetch_type next_st;

	// Walks the display area endlessly; data for the address shown is captured at the next edge
	always_comb begin
		next_st = st;
		next_st.idx = (st.idx == LAST_IDX) ? 5'h0 : st.idx + 5'h1;
		next_st.idx_d = st.idx;
		next_st.primed = 1'b1;
		next_st.addr = DISP_FIRST + {2'h0, st.idx};
		if (st.primed) begin
			next_st.cache[st.idx_d] = i_mem_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_mem_addr = st.addr;
	assign o_cache = st.cache;
endmodule : lcd_fetch

// file: lcd_panel_model.sv
`timescale 1ns/1ps
module lcd_panel_model import lcd_pkg::*; (
	input wire logic i_clk,
	input wire logic i_clear,
	input wire logic i_power_switch,
	input wire logic [SEGS*LVL_W-1:0] i_segment_output,
	input wire logic [COMS*LVL_W-1:0] i_common_output,
	output logic [SEGS*COMS-1:0] o_lit
);
	logic [2:0] s;
	logic [2:0] c;
	// Cells seen lit since the last clear, cell 4*seg+com
	always @(posedge i_clk) begin
		for (int k = 0; k < SEGS*COMS; k++) begin
			s = i_segment_output[3*(k/4)+:3];
			c = i_common_output[3*(k%4)+:3];
			if (i_clear)
				o_lit[k] <= 1'b0;
			else if (i_power_switch && ((s == LV_BOTTOM && c == LV_TOP) ||
					(s == LV_TOP && c == LV_BOTTOM)))
				o_lit[k] <= 1'b1;
		end
	end
endmodule : lcd_panel_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench import lcd_pkg::*; ;
	typedef struct {int kind; logic [79:0] val;} note_type;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic hold = 1'b0;
	logic en = 1'b0;
	logic [1:0] duty = 2'h3;
	logic [1:0] base = 2'h0;
	logic dual = 1'b0;
	logic low_clk = 1'b0;
	logic [3:0] mem_data;
	logic clear = 1'b1;
	logic [6:0] mem_addr;
	logic pwr;
	logic [SEGS*LVL_W-1:0] segment_output;
	logic [COMS*LVL_W-1:0] common_output;
	logic [SEGS*COMS-1:0] lit;
	logic [3:0] mem [SEGS];
	logic [4:0] lc_cnt = 5'h0;
	int seed = 32'h486e345a;
	int num_errors = 0;
	int total_checks = 0;
	int ival;
	int per [4] = '{1024, 2048, 8192, 16384};
	note_type exp_q [$];
	event chk;
	always #25 clk = ~clk;
	// Word for the address shown, sampled at the next edge
	assign mem_data = (mem_addr >= DISP_FIRST && mem_addr <= DISP_LAST) ?
		mem[5'(mem_addr - DISP_FIRST)] : 4'h0;
	// Low clock every 20 cycles
	always @(posedge clk) begin
		lc_cnt <= (lc_cnt == 5'h09) ? 5'h00 : lc_cnt + 5'h01;
		if (lc_cnt == 5'h09)
			low_clk <= ~low_clk;
	end
	lcd_segment_driver u_dut (
		.i_clk(clk), .i_rst_b(rst_b), .i_hold(hold),
		.i_display_enable_bit(en), .i_duty_select(duty),
		.i_base_freq_select(base), .i_dual_clock_mode(dual),
		.i_low_clk(low_clk), .i_mem_data(mem_data), .o_mem_addr(mem_addr),
		.o_power_switch(pwr), .o_segment_output(segment_output), .o_common_output(common_output)
	);
	lcd_panel_model u_panel (
		.i_clk(clk), .i_clear(clear), .i_power_switch(pwr),
		.i_segment_output(segment_output), .i_common_output(common_output), .o_lit(lit)
	);
	task automatic compare(input logic [79:0] e, input logic [79:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH at %0t: expected %h got %h", $time, e, g);
		end
	endtask : compare
	task automatic note(input int kind, input logic [79:0] val);
		@(negedge clk);
		exp_q.push_back('{kind, val});
		-> chk;
	endtask : note
	always @(chk) begin
		note_type n;
		logic [79:0] got;
		n = exp_q.pop_front();
		case (n.kind)
			0: got = 80'(pwr);
			1: got = 80'(common_output);
			2: got = 80'(segment_output);
			3: got = 80'(mem_addr);
			4: got = 80'(lit);
			default: got = 80'(ival);
		endcase
		compare(n.val, got);
	end
	task automatic lit_frame(input logic [79:0] e);
		repeat (100) @(posedge clk);
		clear <= 1'b1;
		@(posedge clk) clear <= 1'b0;
		repeat (4200) @(posedge clk);
		note(4, e);
	endtask : lit_frame
	// Cycles between common changes; early ones are phase-skewed
	task automatic measure(input int e, input int skips);
		logic [COMS*LVL_W-1:0] p;
		int n;
		for (int i = 0; i < skips; i++) begin
			p = common_output;
			n = 0;
			while (common_output === p && n < 40000) begin
				@(negedge clk);
				n++;
			end
		end
		ival = n;
		note(5, 80'(e));
	endtask : measure
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim
	initial begin
		#(120000 * 50);
		num_errors++;
		end_sim();
	end
	initial begin
		for (int k = 0; k < SEGS; k++)
			mem[k] = 4'h0;
		repeat (22) @(posedge clk);
		note(0, 80'h0);
		note(1, 80'h0);
		note(2, 80'h0);
		@(posedge clk) rst_b <= 1'b1;
		note(3, 80'h0);
		for (int k = 0; k < 21; k++)
			note(3, 80'(DISP_FIRST + 7'(k % SEGS)));
		@(posedge clk) en <= 1'b1;
		note(0, 80'h0);
		note(0, 80'h1);
		for (int d = 0; d < 4; d++) begin
			logic [79:0] e;
			@(posedge clk) en <= 1'b0;
			@(posedge clk) duty <= 2'(d);
			@(posedge clk) en <= 1'b1;
			for (int k = 0; k < SEGS; k++) begin
				mem[k] = 4'($random(seed));
				e[4*k+:4] = d == 0 ? {4{mem[k][0]}} : mem[k] & 4'((2 << d) - 1);
			end
			lit_frame(e);
		end
		@(posedge clk) en <= 1'b0;
		note(0, 80'h1);
		lit_frame(80'h0);
		@(posedge clk) duty <= DUTY_STATIC;
		repeat (5) @(posedge clk);
		note(1, 80'h6db);
		@(posedge clk) hold <= 1'b1;
		repeat (2) @(posedge clk);
		note(0, 80'h0);
		note(1, 80'h0);
		@(posedge clk) hold <= 1'b0;
		repeat (2) @(posedge clk);
		note(0, 80'h1);
		@(posedge clk) rst_b <= 1'b0;
		note(0, 80'h0);
		repeat (25) @(posedge clk);
		@(posedge clk) rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		note(0, 80'h0);
		@(posedge clk) duty <= DUTY_QUARTER;
		@(posedge clk) en <= 1'b1;
		for (int b = 0; b < 4; b++) begin
			@(posedge clk) base <= 2'(b);
			measure(per[b], (b == 0) ? 3 : 2);
		end
		@(posedge clk) dual <= 1'b1;
		base <= BASE_SEL_1;
		measure(1280, 3);
		@(posedge clk) base <= BASE_SEL_2;
		measure(2560, 3);
		@(posedge clk);
		end_sim();
	end
endmodule : testbench
